/* hdl/tx_status_pkg.sv */
// Constants for the transmit status block
package tx_status_pkg;
	// Register offsets
	localparam logic [15:0] ADDR_CONTROL = 16'ha008;
	localparam logic [15:0] ADDR_STATUS  = 16'ha00c;
	localparam logic [15:0] ADDR_MASK    = 16'ha100;
	localparam logic [15:0] ADDR_EVENTS  = 16'ha104;
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
	// Status field positions
	localparam int COUNT_LSB    = 0;
	localparam int EXCESS_BIT   = 4;
	localparam int DEFER_BIT    = 5;
	localparam int PAUSE_BIT    = 6;
	localparam int TXINT_BIT    = 7;
	localparam int UNDER_BIT    = 8;
	localparam int TIMEOUT_BIT  = 9;
	localparam int CARRIER_BIT  = 10;
	localparam int SQE_BIT      = 11;
	localparam int LATE_BIT     = 12;
	localparam int PARITY_BIT   = 13;
	localparam int COMP_BIT     = 14;
	localparam int HALT_BIT     = 15;
	// Control field positions
	localparam int EN_BIT       = 0;
	localparam int IMMEDIATE_HALT_BIT_BIT  = 1;
	localparam int SPEED10_BIT  = 2;
	localparam int SQE_EN_BIT   = 7;
	// Timing, clock 20 MHz
	localparam int  CLK_NS        = 50;
	localparam int  DEFER100_NS   = 327680;
	localparam int  DEFER10_NS    = 3276800;
	localparam int  DEFER100_CYC  = DEFER100_NS / CLK_NS;
	localparam int  DEFER10_CYC   = DEFER10_NS / CLK_NS;
	localparam int  SQE_WIN_NS    = 6400;
	localparam int  SQE_WIN_CYC   = SQE_WIN_NS / CLK_NS;
	localparam int  LATE_BITS     = 512;
	localparam logic [4:0] MAX_COLL = 5'h10;
endpackage

/* hdl/sqe_watch.sv */
// Watches for the signal-quality test pulse after each transmission
`timescale 1ns/1ps
module sqe_watch #(
	parameter int WIN_CYC = tx_status_pkg::SQE_WIN_CYC
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// Events
	input  wire logic tx_done,
	input  wire logic col_sync,
	output logic      sqe_missing
);
	logic [15:0] count;
	logic        armed;
	wire         expired = armed && (count == 16'(WIN_CYC - 1));
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			armed       <= 1'b0;
			count       <= 16'h0000;
			sqe_missing <= 1'b0;
		end else begin
			sqe_missing <= expired && !col_sync; // see [R10]
			if (tx_done) begin
				armed <= 1'b1;
				count <= 16'h0000;
			end else if (armed && (col_sync || expired)) begin
				armed <= 1'b0;
			end else if (armed) begin
				count <= count + 16'h0001;
			end
		end
	end
endmodule

/* hdl/tx_status.sv */
// Transmit status register with interrupt logic of an Ethernet MAC
// Notes on behaviour
// [R1] Low four status bits hold collisions of the latest successful packet.
// [R2] Sixteen collisions abort the packet and set excess flag bit 4.
// [R3] Deferred transmission sets bit 5.
// [R4] Transmission held by a pause request sets bit 6.
// [R5] A packet raising an interrupt condition sets bit 7.
// [R6] Transmit FIFO running empty mid packet sets bit 8.
// [R7] Deferring for the maximum deferral time sets bit 9.
// [R8] Carrier sense never seen during a packet sets bit 10.
// [R9] Transceiver pulses collision 1.6 us after a packet, for 1.5 us.
// [R10] Missing signal-quality pulse within 6.4 us sets bit 11.
// [R11] Collision after 512 bit times sets bit 12.
// [R12] Transmit FIFO parity error sets bit 13.
// [R13] Each packet sent or discarded sets bit 14.
// [R14] Halt by clearing enable or immediate halt sets bit 15.
// [R15] Each set flag raises an interrupt when its enable is set; enable bit 11 gates excess collision, not the SQE flag.
// [R16] Parity error also clears transmit enable when its interrupt is enabled.
// [R17] Count is zero while the excess flag is set.
// [R18] Bits 31 to 16 read zero; writes to them are ignored.
// [R19] Flags hold until a software clear; bits 4 to 8, 10 and 12 also clear at the next packet.
`timescale 1ns/1ps
module tx_status #(
	parameter int DEFER100_CYC = tx_status_pkg::DEFER100_CYC,
	parameter int DEFER10_CYC  = tx_status_pkg::DEFER10_CYC,
	parameter int SQE_WIN_CYC  = tx_status_pkg::SQE_WIN_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	// Transmit engine events, one-cycle pulses except the deferring, paused and fifo_empty levels
	input  wire logic        tx_start,
	input  wire logic        tx_done,
	input  wire logic        tx_discard,
	input  wire logic        collision,
	input  wire logic        deferring,
	input  wire logic        paused,
	input  wire logic        fifo_empty,
	input  wire logic        fifo_parity_err,
	input  wire logic        bit_tick,
	// PHY pins
	input  wire logic        phy_crs,
	input  wire logic        phy_col,
	// Control out and interrupt
	output logic             transmit_enable_bit,
	output logic             tx_irq
);
	// Control bits
	logic        immediate_halt_bit;
	logic        speed10;
	logic        sqe_test_en;
	logic [14:8] enables;
	// Status fields
	logic [3:0]  collision_count;
	logic        excess_collision_flag;
	logic        deferred_flag;
	logic        pause_flag;
	logic        transmit_interrupt_flag;
	logic        underrun_flag;
	logic        timeout_flag;
	logic        carrier_lost_flag;
	logic        sqe_flag;
	logic        late_collision_flag;
	logic        fifo_parity_flag;
	logic        completion_flag;
	logic        halted_flag;
	// Generic interrupt block
	logic [15:0] event_status;
	logic [15:0] event_mask;
	// Per-packet tracking, deferral timer, pin synchronisers and SQE result
	logic        in_packet;
	logic [4:0]  coll_run;
	logic [9:0]  bit_count;
	logic        crs_seen;
	logic [21:0] defer_count;
	logic [1:0]  crs_pipe;
	logic [1:0]  col_pipe;
	logic        sqe_missing;

	wire crs_sync = crs_pipe[1];
	wire col_sync = col_pipe[1];

	// Decode
	wire wr_ctrl   = reg_write && (reg_addr == tx_status_pkg::ADDR_CONTROL);
	wire wr_stat   = reg_write && (reg_addr == tx_status_pkg::ADDR_STATUS);
	wire wr_mask   = reg_write && (reg_addr == tx_status_pkg::ADDR_MASK);
	wire wr_events = reg_write && (reg_addr == tx_status_pkg::ADDR_EVENTS);

	// Events
	wire [4:0] coll_next   = coll_run + 5'h01;
	wire       coll_excess = in_packet && collision && (coll_next == tx_status_pkg::MAX_COLL);
	wire       late_ev     = in_packet && collision && (bit_count >= 10'(tx_status_pkg::LATE_BITS));
	wire       under_ev    = in_packet && fifo_empty;
	wire [21:0] defer_lim  = speed10 ? 22'(DEFER10_CYC - 1) : 22'(DEFER100_CYC - 1);
	wire       timeout_ev  = deferring && (defer_count == defer_lim);
	wire       pkt_end     = tx_done || tx_discard || coll_excess;
	wire       nocarr_ev   = tx_done && !crs_seen && !crs_sync;
	wire       halt_ev     = wr_ctrl && ((transmit_enable_bit && !reg_wdata[tx_status_pkg::EN_BIT])
	                        || (!immediate_halt_bit && reg_wdata[tx_status_pkg::IMMEDIATE_HALT_BIT_BIT]));
	wire       sqe_ev      = sqe_missing && sqe_test_en;
	wire       err_int     = (under_ev && enables[8]) || (timeout_ev && enables[9])
	                        || (nocarr_ev && enables[10]) || (coll_excess && enables[11])
	                        || (late_ev && enables[12]) || (fifo_parity_err && enables[13])
	                        || (pkt_end && enables[14]);
	wire [15:0] status_word = {halted_flag, completion_flag, fifo_parity_flag, late_collision_flag,
	                           sqe_flag, carrier_lost_flag, timeout_flag, underrun_flag,
	                           transmit_interrupt_flag, pause_flag, deferred_flag,
	                           excess_collision_flag, collision_count};
	wire [15:0] ctrl_word   = {1'b0, enables, sqe_test_en, 4'h0, speed10, immediate_halt_bit,
	                           transmit_enable_bit};
	wire [15:0] event_set   = {halt_ev, pkt_end, fifo_parity_err, late_ev, sqe_ev, nocarr_ev,
	                           timeout_ev, under_ev, err_int, paused, deferring, coll_excess, 4'h0};
	wire [15:0] clr_mask    = wr_events ? reg_wdata[15:0] : 16'h0000;
	wire [31:0] read_mux    = (reg_addr == tx_status_pkg::ADDR_CONTROL) ? {16'h0000, ctrl_word} :
	                          (reg_addr == tx_status_pkg::ADDR_STATUS)  ? {16'h0000, status_word} :
	                          (reg_addr == tx_status_pkg::ADDR_MASK)    ? {16'h0000, event_mask} :
	                          (reg_addr == tx_status_pkg::ADDR_EVENTS)  ? {16'h0000, event_status} :
	                          32'h0000_0000; // see [R18]

	sqe_watch #(
		.WIN_CYC     (SQE_WIN_CYC)
	) u_sqe (
		.sys_clk     (sys_clk),
		.srst        (srst),
		.tx_done     (tx_done),
		.col_sync    (col_sync),
		.sqe_missing (sqe_missing)
	);

	// Pin synchronisers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			crs_pipe <= 2'b00;
			col_pipe <= 2'b00;
		end else begin
			crs_pipe <= {crs_pipe[0], phy_crs};
			col_pipe <= {col_pipe[0], phy_col};
		end
	end

	// Control register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			transmit_enable_bit <= 1'b0;
			immediate_halt_bit  <= 1'b0;
			speed10             <= 1'b0;
			sqe_test_en         <= 1'b0;
			enables             <= 7'h00;
		end else begin
			if (wr_ctrl) begin
				transmit_enable_bit <= reg_wdata[tx_status_pkg::EN_BIT];
				immediate_halt_bit  <= reg_wdata[tx_status_pkg::IMMEDIATE_HALT_BIT_BIT];
				speed10             <= reg_wdata[tx_status_pkg::SPEED10_BIT];
				sqe_test_en         <= reg_wdata[tx_status_pkg::SQE_EN_BIT];
				enables             <= reg_wdata[14:8];
			end
			if (fifo_parity_err && enables[13])
				transmit_enable_bit <= 1'b0; // see [R16]
		end
	end

	// Packet tracking
	always_ff @(posedge sys_clk) begin
		if (srst || tx_start) begin
			in_packet <= tx_start;
			coll_run  <= 5'h00;
			bit_count <= 10'h000;
			crs_seen  <= 1'b0;
		end else begin
			if (pkt_end)
				in_packet <= 1'b0;
			if (in_packet && collision)
				coll_run <= coll_next;
			if (in_packet && bit_tick && bit_count != 10'h3ff)
				bit_count <= bit_count + 10'h001;
			if (in_packet && crs_sync)
				crs_seen <= 1'b1;
		end
	end

	// Deferral timer
	always_ff @(posedge sys_clk) begin
		if (srst || !deferring || timeout_ev)
			defer_count <= 22'h000000;
		else
			defer_count <= defer_count + 22'h000001;
	end

	// Status register; hardware set wins over software clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			{halted_flag, completion_flag, fifo_parity_flag, late_collision_flag, sqe_flag,
			 carrier_lost_flag, timeout_flag, underrun_flag, transmit_interrupt_flag,
			 pause_flag, deferred_flag, excess_collision_flag} <= 12'h000;
			collision_count <= 4'h0;
		end else begin
			if (tx_start) begin
				{excess_collision_flag, deferred_flag, pause_flag, transmit_interrupt_flag,
				 underrun_flag, carrier_lost_flag, late_collision_flag} <= 7'h00; // see [R19]
			end else if (wr_stat) begin
				{halted_flag, completion_flag, fifo_parity_flag, late_collision_flag, sqe_flag,
				 carrier_lost_flag, timeout_flag, underrun_flag, transmit_interrupt_flag,
				 pause_flag, deferred_flag, excess_collision_flag} <=
				{halted_flag, completion_flag, fifo_parity_flag, late_collision_flag, sqe_flag,
				 carrier_lost_flag, timeout_flag, underrun_flag, transmit_interrupt_flag,
				 pause_flag, deferred_flag, excess_collision_flag} & ~reg_wdata[15:4]; // see [R19]
			end
			if (tx_done)
				collision_count <= coll_run[3:0]; // see [R1]
			if (coll_excess) begin
				excess_collision_flag <= 1'b1; // see [R2]
				collision_count       <= 4'h0; // see [R17]
			end
			if (in_packet && deferring) deferred_flag <= 1'b1; // see [R3]
			if (in_packet && paused) pause_flag <= 1'b1; // see [R4]
			if (err_int) transmit_interrupt_flag <= 1'b1; // see [R5]
			if (under_ev) underrun_flag <= 1'b1; // see [R6]
			if (timeout_ev) timeout_flag <= 1'b1; // see [R7]
			if (nocarr_ev) carrier_lost_flag <= 1'b1; // see [R8]
			if (sqe_ev) sqe_flag <= 1'b1; // see [R9] [R10]
			if (late_ev) late_collision_flag <= 1'b1; // see [R11]
			if (fifo_parity_err) fifo_parity_flag <= 1'b1; // see [R12]
			if (pkt_end) completion_flag <= 1'b1; // see [R13]
			if (halt_ev) halted_flag <= 1'b1; // see [R14]
		end
	end

	// Interrupt status, mask and output
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			event_status <= 16'h0000;
			event_mask   <= 16'h0000;
			tx_irq       <= 1'b0;
			reg_rdata    <= tx_status_pkg::RESET_WORD;
		end else begin
			event_status <= (event_status & ~clr_mask) | event_set;
			if (wr_mask)
				event_mask <= reg_wdata[15:0];
			tx_irq    <= |(event_status & event_mask) || err_int; // see [R15]
			reg_rdata <= reg_read ? read_mux : 32'h0000_0000;
		end
	end

	a_excess_zero: assert property (@(posedge sys_clk) disable iff (srst) // see [R17]
		excess_collision_flag |-> collision_count == 4'h0) else $error("count nonzero with excess flag");
	a_excess_set: assert property (@(posedge sys_clk) disable iff (srst) // see [R2]
		coll_excess |=> excess_collision_flag && !in_packet) else $error("excess collision not handled");
	a_count_load: assert property (@(posedge sys_clk) disable iff (srst) // see [R1]
		tx_done && !coll_excess |=> collision_count == $past(coll_run[3:0])) else $error("count wrong");
	a_comp_set: assert property (@(posedge sys_clk) disable iff (srst) // see [R13]
		pkt_end |=> completion_flag) else $error("completion missing");
	a_parity_stop: assert property (@(posedge sys_clk) disable iff (srst) // see [R16]
		fifo_parity_err && enables[13] |=> !transmit_enable_bit && fifo_parity_flag) else $error("parity");
	a_halt_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R14]
		halt_ev |=> halted_flag) else $error("halt flag missing");
	a_late_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R11]
		late_ev |=> late_collision_flag) else $error("late collision missing");
	a_under_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R6]
		under_ev |=> underrun_flag) else $error("underrun missing");
	a_sqe_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R10]
		sqe_missing && sqe_test_en |=> sqe_flag) else $error("sqe flag missing");
	a_irq_raise: assert property (@(posedge sys_clk) disable iff (srst) // see [R15]
		(|(event_status & event_mask)) |=> tx_irq) else $error("irq not raised");
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (srst) // see [R18]
		reg_rdata[31:16] == 16'h0000) else $error("reserved bits nonzero");

	// Per-event flag checks
	a_defer_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R3]
		in_packet && deferring |=> deferred_flag) else $error("deferred flag missing");
	a_pause_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R4]
		in_packet && paused |=> pause_flag) else $error("pause flag missing");
	a_txint_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R5]
		err_int |=> transmit_interrupt_flag) else $error("interrupt flag missing");
	a_timeout_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R7]
		timeout_ev |=> timeout_flag) else $error("timeout flag missing");
	a_nocarr_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R8]
		nocarr_ev |=> carrier_lost_flag) else $error("no carrier flag missing");
	a_parity_flag: assert property (@(posedge sys_clk) disable iff (srst) // see [R12]
		fifo_parity_err |=> fifo_parity_flag) else $error("parity flag missing");

	// Packet opening clears the per-packet trackers
	sequence s_pkt_open;
		tx_start;
	endsequence
	a_pkt_open: assert property (@(posedge sys_clk) disable iff (srst) // see [R1]
		s_pkt_open |=> in_packet && coll_run == 5'h00 && bit_count == 10'h000) else $error("packet open");

	// Flags survive idle cycles; read data is zero when no read is made
	a_flag_hold: assert property (@(posedge sys_clk) disable iff (srst) // see [R19]
		late_collision_flag && !tx_start && !wr_stat |=> late_collision_flag) else $error("flag lost");
	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (srst) // see [R18]
		!reg_read |=> reg_rdata == 32'h0000_0000) else $error("read data not idle");
endmodule

/* dv/phy_model.sv */
// Behavioural transceiver driving carrier and collision pins
`timescale 1ns/1ps
module phy_model (
	// Clock
	input  wire logic sys_clk,
	// Commands from the bench
	input  wire logic tx_on,
	input  wire logic tx_done,
	input  wire logic sqe_off,
	// Pins towards the MAC
	output logic      phy_crs,
	output logic      phy_col
);
	int cnt = 0;
	// Carrier only while a frame is on the wire
	assign phy_crs = tx_on;
	// Test pulse 1.6 us after a frame, 1.5 us long
	always @(posedge sys_clk) begin
		if (tx_done && !sqe_off)
			cnt <= 1;
		else if (cnt != 0)
			cnt <= (cnt == 62) ? 0 : cnt + 1;
	end
	assign phy_col = (cnt > 32);
endmodule

/* dv/testbench.sv */
// Self-checking bench for the transmit status block
`timescale 1ns/1ps
module testbench;
	logic        sys_clk   = 1'h0;
	logic        srst      = 1'h1;
	logic [15:0] reg_addr  = 16'h0000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_write = 1'h0;
	logic        reg_read  = 1'h0;
	logic [31:0] reg_rdata;
	logic [5:0]  evp       = 6'h00;
	logic [2:0]  lv        = 3'h0;
	logic        tx_on     = 1'h0;
	logic        sqe_off   = 1'h0;
	logic        phy_crs;
	logic        phy_col;
	logic        en_bit;
	logic        irq;
	int          miscompares = 0;
	int          checks      = 0;

	tx_status #(.DEFER100_CYC(20), .DEFER10_CYC(40), .SQE_WIN_CYC(128)) dut_u (
		.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.tx_start(evp[0]), .tx_done(evp[1]), .tx_discard(evp[2]), .collision(evp[3]),
		.deferring(lv[0]), .paused(lv[1]), .fifo_empty(lv[2]), .fifo_parity_err(evp[4]),
		.bit_tick(evp[5]), .phy_crs(phy_crs), .phy_col(phy_col),
		.transmit_enable_bit(en_bit), .tx_irq(irq));
	phy_model phy_u (.sys_clk(sys_clk), .tx_on(tx_on), .tx_done(evp[1]), .sqe_off(sqe_off),
		.phy_crs(phy_crs), .phy_col(phy_col));

	initial forever #25 sys_clk = ~sys_clk;

	task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'h1;
		@(posedge sys_clk);
		reg_write <= 1'h0;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] m, e, input string w);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge sys_clk);
		reg_read <= 1'h0;
		#1 check(w, reg_rdata & m, e);
	endtask
	task automatic st(input logic [31:0] m, e, input string w);
		rchk(tx_status_pkg::ADDR_STATUS, m, e, w);
	endtask
	task automatic clr();
		wr(tx_status_pkg::ADDR_STATUS, 32'h0000_fff0);
		wr(tx_status_pkg::ADDR_EVENTS, 32'h0000_fff0);
	endtask
	task automatic ev(input int k, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			evp[k] <= 1'h1;
			@(posedge sys_clk);
			evp[k] <= 1'h0;
		end
	endtask
	// Frame: start, bit ticks, collisions, optional normal end
	task automatic pkt(input int nc, input int nt, input bit cr, input bit done);
		tx_on <= cr;
		ev(0, 1);
		ev(5, nt);
		ev(3, nc);
		if (done)
			ev(1, 1);
		tx_on <= 1'h0;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_reset();
		rchk(tx_status_pkg::ADDR_CONTROL, 32'hffff_ffff, 32'h0000_0000, "control reset");
		st(32'hffff_ffff, tx_status_pkg::RESET_WORD, "status reset");
		rchk(tx_status_pkg::ADDR_MASK, 32'hffff_ffff, 32'h0000_0000, "mask reset");
		rchk(16'h0000, 32'hffff_ffff, 32'h0000_0000, "unmapped");
		wr(tx_status_pkg::ADDR_STATUS, 32'hffff_ffff);
		st(32'hffff_0000, 32'h0000_0000, "reserved");
		$display("test reset done");
	endtask
	task automatic t_count();
		clr();
		pkt(3, 0, 1, 1);
		st(32'h0000_441f, 32'h0000_4003, "count");
		pkt(16, 0, 1, 0);
		st(32'h0000_001f, 32'h0000_0010, "excess");
		clr();
		ev(0, 1);
		ev(2, 1);
		st(32'h0000_4000, 32'h0000_4000, "discard");
		$display("test count done");
	endtask
	task automatic t_flags();
		clr();
		lv <= 3'h7;
		pkt(0, 0, 0, 1);
		lv <= 3'h0;
		st(32'h0000_ffff, 32'h0000_4560, "flags");
		st(32'h0000_ffff, 32'h0000_4560, "flags held");
		pkt(0, 0, 1, 1);
		st(32'h0000_0560, 32'h0000_0000, "flags renewed");
		pkt(1, 511, 1, 1);
		st(32'h0000_1000, 32'h0000_0000, "early collision");
		pkt(1, 512, 1, 1);
		st(32'h0000_1000, 32'h0000_1000, "late collision");
		$display("test flags done");
	endtask
	task automatic t_defer();
		clr();
		lv <= 3'h1;
		repeat (25) @(posedge sys_clk);
		lv <= 3'h0;
		st(32'h0000_0200, 32'h0000_0200, "timeout fast");
		clr();
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_0004);
		lv <= 3'h1;
		repeat (25) @(posedge sys_clk);
		lv <= 3'h0;
		st(32'h0000_0200, 32'h0000_0000, "timeout slow early");
		lv <= 3'h1;
		repeat (45) @(posedge sys_clk);
		lv <= 3'h0;
		st(32'h0000_0200, 32'h0000_0200, "timeout slow");
		$display("test defer done");
	endtask
	task automatic t_sqe();
		clr();
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_0080);
		pkt(0, 0, 1, 1);
		repeat (140) @(posedge sys_clk);
		st(32'h0000_0800, 32'h0000_0000, "sqe seen");
		sqe_off <= 1'h1;
		pkt(0, 0, 1, 1);
		repeat (140) @(posedge sys_clk);
		sqe_off <= 1'h0;
		st(32'h0000_0800, 32'h0000_0800, "sqe missing");
		$display("test sqe done");
	endtask
	task automatic t_halt();
		clr();
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_0001);
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_0000);
		st(32'h0000_8000, 32'h0000_8000, "halt by enable");
		clr();
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_0002);
		st(32'h0000_8000, 32'h0000_8000, "halt immediate");
		$display("test halt done");
	endtask
	task automatic t_parity();
		clr();
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_0001);
		ev(4, 1);
		st(32'h0000_2000, 32'h0000_2000, "parity flag");
		check("enable kept", 32'(en_bit), 32'h0000_0001);
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_2001);
		ev(4, 1);
		repeat (2) @(posedge sys_clk);
		#1 check("enable cleared", 32'(en_bit), 32'h0000_0000);
		$display("test parity done");
	endtask
	task automatic t_irq();
		clr();
		wr(tx_status_pkg::ADDR_CONTROL, 32'h0000_4001);
		wr(tx_status_pkg::ADDR_MASK, 32'h0000_4000);
		pkt(0, 0, 1, 1);
		#1 check("irq raised", 32'(irq), 32'h0000_0001);
		st(32'h0000_4080, 32'h0000_4080, "tx interrupt");
		wr(tx_status_pkg::ADDR_EVENTS, 32'h0000_4000);
		repeat (2) @(posedge sys_clk);
		#1 check("irq cleared", 32'(irq), 32'h0000_0000);
		wr(tx_status_pkg::ADDR_MASK, 32'h0000_0000);
		$display("test irq done");
	endtask

	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'h0;
		t_reset();
		t_count();
		t_flags();
		t_defer();
		t_sqe();
		t_halt();
		t_parity();
		t_irq();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		final_report();
	end
endmodule
